// ### hdl/logic_array_defs.svh
// register offsets, field positions and reset values of the logic array
`ifndef LOGIC_ARRAY_DEFS_SVH
`define LOGIC_ARRAY_DEFS_SVH

`define LA_NUM_ELEM 16
`define LA_BLOCK_SIZE 8
`define LA_ELEM_IDX_W 4
`define LA_SYNC_STAGES 2

`define LA_OFF_ELEM_BASE 8'h00
`define LA_OFF_ELEM_LAST 8'h3c
`define LA_OFF_CLKSEL 8'h40
`define LA_OFF_IRQSEL 8'h44
`define LA_OFF_CONVSEL 8'h48
`define LA_OFF_SWDIN 8'h4c
`define LA_OFF_READBACK 8'h50
`define LA_ADDR_W 8
`define LA_WORD_LSB 2

`define LA_EC_W 11
`define LA_EC_RESET 11'h000

`define LA_CS_W 8
`define LA_CS_B0_HI 2
`define LA_CS_B0_LO 0
`define LA_CS_B1_HI 6
`define LA_CS_B1_LO 4
`define LA_CS_MASK 8'h77
`define LA_CS_RESET 8'h00

`define LA_IRQ_W 13
`define LA_IRQ0_EN 4
`define LA_IRQ0_SRC_HI 3
`define LA_IRQ0_SRC_LO 0
`define LA_IRQ1_EN 12
`define LA_IRQ1_SRC_HI 11
`define LA_IRQ1_SRC_LO 8
`define LA_IRQ_MASK 13'h1f1f
`define LA_IRQ_RESET 13'h0000

`define LA_CONV_W 5
`define LA_CONV_EN 4
`define LA_CONV_SRC_HI 3
`define LA_CONV_SRC_LO 0
`define LA_CONV_RESET 5'h00

`define LA_DATA_W 16
`define LA_DATA_RESET 16'h0000

`endif

// ### hdl/logic_array_pkg.sv
// types shared by the logic array files
package logic_array_pkg;

  // element control word, bit 10 down to bit 0
  typedef struct packed {
    logic [1:0] fb0Sel;
    logic [1:0] fb1Sel;
    logic aFromFb;
    logic bFromPin;
    logic [3:0] truthTable;
    logic bypassFf;
  } elem_cfg_s;

  typedef enum logic [2:0] {
    CLK_PIN_A = 3'b000,
    CLK_PIN_B = 3'b001,
    CLK_PIN_C = 3'b010,
    CLK_CORE = 3'b011,
    CLK_OSC = 3'b100,
    CLK_TMR1 = 3'b101,
    CLK_TMR4 = 3'b110,
    CLK_NONE = 3'b111
  } clk_src_e;

  typedef struct packed {
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// ### hdl/sync_2ff.sv
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`include "logic_array_defs.svh"
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign syncOut = sync_r;
endmodule

// ### hdl/logic_element.sv
// one array element: input muxes, two-input lookup table and flip-flop
`timescale 1ns/1ps
module logic_element
  import logic_array_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input elem_cfg_s cfg,
  input wire logic [3:0] fb0Choice,
  input wire logic [3:0] fb1Choice,
  input wire logic swBit,
  input wire logic pinBit,
  input wire logic tick,
  output logic elemOut
);
  logic inA;
  logic inB;
  logic lutOut;
  logic ff_r;
  logic ff_nxt;

  always_comb begin
    inA = cfg.aFromFb ? fb0Choice[cfg.fb0Sel] : swBit;
    inB = cfg.bFromPin ? pinBit : fb1Choice[cfg.fb1Sel];
    lutOut = cfg.truthTable[{inA, inB}];
    ff_nxt = tick ? lutOut : ff_r;
    elemOut = cfg.bypassFf ? lutOut : ff_r;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_r <= 1'b0;
    end else begin
      ff_r <= ff_nxt;
    end
  end
endmodule

// ### hdl/logic_array.sv
// register-controlled sixteen-element programmable logic array with APB access
`timescale 1ns/1ps
`include "logic_array_defs.svh"
module logic_array
  import logic_array_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] elemPin,
  input wire logic [2:0] gpioClkPin,
  input wire logic oscClkPin,
  input wire logic timer1Ovf,
  input wire logic timer4Ovf,
  output logic [15:0] elemOut,
  output logic irqReq0,
  output logic irqReq1,
  output logic convStart
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [`LA_EC_W-1:0] elemCtl_r [`LA_NUM_ELEM];
  logic [`LA_EC_W-1:0] elemCtl_nxt [`LA_NUM_ELEM];
  logic [`LA_CS_W-1:0] clkSel_r;
  logic [`LA_CS_W-1:0] clkSel_nxt;
  logic [`LA_IRQ_W-1:0] irqSel_r;
  logic [`LA_IRQ_W-1:0] irqSel_nxt;
  logic [`LA_CONV_W-1:0] convSel_r;
  logic [`LA_CONV_W-1:0] convSel_nxt;
  logic [`LA_DATA_W-1:0] swDin_r;
  logic [`LA_DATA_W-1:0] swDin_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  apb_req_s req;
  logic accessDone;
  logic elemHit;
  logic [`LA_ELEM_IDX_W-1:0] elemIdx;

  // ---------------------------------------------------------------
  // array datapath signals
  // ---------------------------------------------------------------
  logic [`LA_DATA_W-1:0] elemLive;
  logic [`LA_DATA_W-1:0] pinSync;
  logic [2:0] gpioClkSync;
  logic oscSync;
  logic [5:0] srcLevel;
  logic [5:0] srcPrev_r;
  logic [5:0] srcPrev_nxt;
  logic [5:0] srcRise;
  logic [1:0] blockTick;
  logic [`LA_DATA_W-1:0] elemOut_r;
  logic [`LA_DATA_W-1:0] elemOut_nxt;
  logic irq0_r;
  logic irq0_nxt;
  logic irq1_r;
  logic irq1_nxt;
  logic conv_r;
  logic conv_nxt;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  sync_2ff #(.WIDTH(`LA_DATA_W)) pinSyncInst (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn(elemPin),
    .syncOut(pinSync)
  );

  sync_2ff #(.WIDTH(4)) clkSyncInst (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn({oscClkPin, gpioClkPin}),
    .syncOut({oscSync, gpioClkSync})
  );

  // ---------------------------------------------------------------
  // flip-flop clock selection
  // ---------------------------------------------------------------
  // clock sources are sampled by clk; a block tick is one rising edge of the selected source, or every cycle for CLK_CORE
  always_comb begin
    srcLevel = {timer4Ovf, timer1Ovf, oscSync, gpioClkSync};
    srcPrev_nxt = srcLevel;
    srcRise = srcLevel & ~srcPrev_r;
  end

  for (genvar b = 0; b < 2; b++) begin : gBlkClk
    clk_src_e src;
    always_comb begin
      if (b == 0) begin
        src = clk_src_e'(clkSel_r[`LA_CS_B0_HI:`LA_CS_B0_LO]);
      end else begin
        src = clk_src_e'(clkSel_r[`LA_CS_B1_HI:`LA_CS_B1_LO]);
      end
      case (src)
        CLK_PIN_A: blockTick[b] = srcRise[0];
        CLK_PIN_B: blockTick[b] = srcRise[1];
        CLK_PIN_C: blockTick[b] = srcRise[2];
        CLK_CORE: blockTick[b] = 1'b1;
        CLK_OSC: blockTick[b] = srcRise[3];
        CLK_TMR1: blockTick[b] = srcRise[4];
        CLK_TMR4: blockTick[b] = srcRise[5];
        CLK_NONE: blockTick[b] = 1'b0;
        default: blockTick[b] = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // elements
  // ---------------------------------------------------------------
  for (genvar e = 0; e < `LA_NUM_ELEM; e++) begin : gElem
    localparam int BASE = (e / `LA_BLOCK_SIZE) * `LA_BLOCK_SIZE;
    localparam int OTHER7 = (BASE + `LA_BLOCK_SIZE + 7) % `LA_NUM_ELEM;
    logic [3:0] fb0;
    logic [3:0] fb1;
    always_comb begin
      // first feedback: code 00 is element 7 of the other block at position 0
      fb0[0] = (e == BASE) ? elemLive[OTHER7] : elemLive[BASE];
      fb0[1] = elemLive[BASE + 2];
      fb0[2] = elemLive[BASE + 4];
      fb0[3] = elemLive[BASE + 6];
      fb1[0] = elemLive[BASE + 1];
      fb1[1] = elemLive[BASE + 3];
      fb1[2] = elemLive[BASE + 5];
      fb1[3] = elemLive[BASE + 7];
    end
    logic_element elemInst (
      .clk(clk),
      .rst_b(rst_b),
      .cfg(elem_cfg_s'(elemCtl_r[e])),
      .fb0Choice(fb0),
      .fb1Choice(fb1),
      .swBit(swDin_r[e]),
      .pinBit(pinSync[e]),
      .tick(blockTick[e / `LA_BLOCK_SIZE]),
      .elemOut(elemLive[e])
    );
  end

  // ---------------------------------------------------------------
  // outputs to pins, interrupt controller and converter
  // ---------------------------------------------------------------
  always_comb begin
    elemOut_nxt = elemLive;
    irq0_nxt = irqSel_r[`LA_IRQ0_EN] &
      elemLive[irqSel_r[`LA_IRQ0_SRC_HI:`LA_IRQ0_SRC_LO]];
    irq1_nxt = irqSel_r[`LA_IRQ1_EN] &
      elemLive[irqSel_r[`LA_IRQ1_SRC_HI:`LA_IRQ1_SRC_LO]];
    conv_nxt = convSel_r[`LA_CONV_EN] &
      elemLive[convSel_r[`LA_CONV_SRC_HI:`LA_CONV_SRC_LO]];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      srcPrev_r <= 6'h00;
      elemOut_r <= `LA_DATA_RESET;
      irq0_r <= 1'b0;
      irq1_r <= 1'b0;
      conv_r <= 1'b0;
    end else begin
      srcPrev_r <= srcPrev_nxt;
      elemOut_r <= elemOut_nxt;
      irq0_r <= irq0_nxt;
      irq1_r <= irq1_nxt;
      conv_r <= conv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // APB slave: one wait state, answer in the second access cycle
  // ---------------------------------------------------------------
  always_comb begin
    req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    accessDone = psel & penable & ~pready_r;
    elemHit = (req.paddr <= `LA_OFF_ELEM_LAST) && (req.paddr[1:0] == 2'b00);
    elemIdx = req.paddr[`LA_WORD_LSB +: `LA_ELEM_IDX_W];
  end

  always_comb begin
    elemCtl_nxt = elemCtl_r;
    clkSel_nxt = clkSel_r;
    irqSel_nxt = irqSel_r;
    convSel_nxt = convSel_r;
    swDin_nxt = swDin_r;
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    pready_nxt = accessDone;
    if (accessDone) begin
      if (elemHit) begin
        if (req.pwrite) begin
          elemCtl_nxt[elemIdx] = req.pwdata[`LA_EC_W-1:0];
        end else begin
          prdata_nxt = {21'h000000, elemCtl_r[elemIdx]};
        end
      end else begin
        case (req.paddr)
          `LA_OFF_CLKSEL: begin
            if (req.pwrite) begin
              clkSel_nxt = req.pwdata[`LA_CS_W-1:0] & `LA_CS_MASK;
            end
            prdata_nxt = {24'h000000, clkSel_r};
          end
          `LA_OFF_IRQSEL: begin
            if (req.pwrite) begin
              irqSel_nxt = req.pwdata[`LA_IRQ_W-1:0] & `LA_IRQ_MASK;
            end
            prdata_nxt = {19'h00000, irqSel_r};
          end
          `LA_OFF_CONVSEL: begin
            if (req.pwrite) begin
              convSel_nxt = req.pwdata[`LA_CONV_W-1:0];
            end
            prdata_nxt = {27'h0000000, convSel_r};
          end
          `LA_OFF_SWDIN: begin
            if (req.pwrite) begin
              swDin_nxt = req.pwdata[`LA_DATA_W-1:0];
            end
            prdata_nxt = {16'h0000, swDin_r};
          end
          `LA_OFF_READBACK: begin
            prdata_nxt = {16'h0000, elemOut_r};
          end
          default: begin
            pslverr_nxt = 1'b1;
          end
        endcase
        if (!req.pwrite) begin
          prdata_nxt = pslverr_nxt ? 32'h0000_0000 : prdata_nxt;
        end else begin
          prdata_nxt = 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `LA_NUM_ELEM; i++) begin
        elemCtl_r[i] <= `LA_EC_RESET;
      end
      clkSel_r <= `LA_CS_RESET;
      irqSel_r <= `LA_IRQ_RESET;
      convSel_r <= `LA_CONV_RESET;
      swDin_r <= `LA_DATA_RESET;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      elemCtl_r <= elemCtl_nxt;
      clkSel_r <= clkSel_nxt;
      irqSel_r <= irqSel_nxt;
      convSel_r <= convSel_nxt;
      swDin_r <= swDin_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign elemOut = elemOut_r;
  assign irqReq0 = irq0_r;
  assign irqReq1 = irq1_r;
  assign convStart = conv_r;

endmodule

// ### verif/logic_array_checker.sv
// port checker for the logic array
`timescale 1ns/1ps
module logic_array_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] elemOut,
  input wire logic irqReq0,
  input wire logic irqReq1,
  input wire logic convStart
);
  // ------------------------------
  // shadow of the request selectors
  // ------------------------------
  logic [12:0] irqSel_r, irqSel_nxt;
  logic [4:0] convSel_r, convSel_nxt;
  logic done;
  always_comb begin
    done = psel && penable && pready && pwrite;
    irqSel_nxt = irqSel_r;
    convSel_nxt = convSel_r;
    if (done && paddr == 8'h44) irqSel_nxt = pwdata[12:0];
    if (done && paddr == 8'h48) convSel_nxt = pwdata[4:0];
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irqSel_r <= 13'h0000;
      convSel_r <= 5'h00;
    end else begin
      irqSel_r <= irqSel_nxt;
      convSel_r <= convSel_nxt;
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  answer_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  answer_cause_a: assert property (pready |-> $past(psel) && $past(penable))
    else $error("pready unasked");
  error_timing_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  idle_data_a: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not idle");
  first_irq_a: assert property ($stable(irqSel_r) |->
    irqReq0 == (irqSel_r[4] && elemOut[irqSel_r[3:0]])) else $error("irq0 wrong");
  second_irq_a: assert property ($stable(irqSel_r) |->
    irqReq1 == (irqSel_r[12] && elemOut[irqSel_r[11:8]])) else $error("irq1 wrong");
  conv_start_a: assert property ($stable(convSel_r) |->
    convStart == (convSel_r[4] && elemOut[convSel_r[3:0]])) else $error("start wrong");
endmodule

bind logic_array logic_array_checker i_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .elemOut, .irqReq0, .irqReq1, .convStart);

// ### verif/logic_array_far.sv
// far-side model: element pins, clock pins, oscillator and timer overflows
`timescale 1ns/1ps
module logic_array_far (
  input wire logic clk,
  input wire logic [15:0] pinLevel,
  input wire logic [2:0] pulseCode,
  input wire logic pulseGo,
  output logic [15:0] elemPin,
  output logic [2:0] gpioClkPin,
  output logic oscClkPin,
  output logic timer1Ovf,
  output logic timer4Ovf
);
  // ------------------------------
  // one three-cycle pulse on the chosen source
  // ------------------------------
  logic [1:0] cnt_r = 2'h0;
  logic on;
  always_ff @(posedge clk) begin
    cnt_r <= pulseGo ? 2'h3 : cnt_r - 2'(cnt_r != 2'h0);
  end
  assign on = cnt_r != 2'h0;
  assign elemPin = pinLevel;
  assign gpioClkPin = on && pulseCode < 3'h3 ? 3'h1 << pulseCode : 3'h0;
  assign oscClkPin = on && pulseCode == 3'h4;
  assign timer1Ovf = on && pulseCode == 3'h5;
  assign timer4Ovf = on && pulseCode == 3'h6;
endmodule

// ### verif/logic_array_tb.sv
// self-checking testbench for the logic array
`timescale 1ns/1ps
module logic_array_tb;
  // ------------------------------
  // harness
  // ------------------------------
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic pready, pslverr, re, irqReq0, irqReq1, convStart, oscClkPin, timer1Ovf, timer4Ovf;
  logic [15:0] elemPin, elemOut, pinLevel = 16'h0;
  logic [2:0] gpioClkPin, pulseCode = 3'h0;
  logic pulseGo = 1'b0;
  int badCount = 0, checked = 0;
  logic_array i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .elemPin, .gpioClkPin, .oscClkPin, .timer1Ovf, .timer4Ovf, .elemOut, .irqReq0,
    .irqReq1, .convStart);
  logic_array_far i_far (.clk, .pinLevel, .pulseCode, .pulseGo, .elemPin, .gpioClkPin,
    .oscClkPin, .timer1Ovf, .timer4Ovf);
  task automatic report_and_stop;
    $display("mismatches %0d of %0d comparisons", badCount, checked);
    if (badCount == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      badCount++;
      report_and_stop();
    end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic s_regs;
    logic [7:0] ad [6] = '{8'h0c, 8'h40, 8'h44, 8'h48, 8'h4c, 8'h50};
    logic [31:0] ex [6] = '{32'h7ff, 32'h77, 32'h1f1f, 32'h1f, 32'hffff, 32'h8};
    for (int i = 0; i < 21; i++) begin
      apb(8'(i * 4), 1'b0, 32'h0);
      chk("reset", 32'h0, rq);
    end
    for (int i = 0; i < 6; i++) begin
      apb(ad[i], 1'b1, 32'hffffffff);
      apb(ad[i], 1'b0, 32'h0);
      chk("mask", ex[i], rq);
    end
    apb(8'h54, 1'b0, 32'h0);
    chk("pslverr", 32'h1, 32'(re));
    for (int i = 0; i < 5; i++) apb(ad[i], 1'b1, 32'h0);
  endtask
  task automatic s_lut;
    for (int t = 0; t < 16; t++) begin
      apb(8'h08, 1'b1, 32'h21 | 32'(t << 1));
      for (int v = 0; v < 4; v++) begin
        apb(8'h4c, 1'b1, 32'(v[1]) << 2);
        pinLevel <= 16'(v[0]) << 2;
        waitc(5);
        chk("lut", 32'(t[v]), 32'(elemOut[2]));
      end
    end
    apb(8'h08, 1'b1, 32'h0);
  endtask
  task automatic s_route;
    int rt [9][3] = '{'{0, 12'h059, 15}, '{0, 12'h259, 2}, '{0, 12'h659, 6}, '{1, 12'h459, 4},
      '{8, 12'h059, 7}, '{9, 12'h059, 8}, '{0, 12'h195, 7}, '{9, 12'h195, 15}, '{8, 12'h015, 9}};
    for (int i = 0; i < 9; i++) begin
      apb(8'(rt[i][2] * 4), 1'b1, 32'h19);
      apb(8'(rt[i][0] * 4), 1'b1, 32'(rt[i][1]));
      for (int b = 1; b >= 0; b--) begin
        apb(8'h4c, 1'b1, 32'(b) << rt[i][2]);
        waitc(5);
        apb(8'h50, 1'b0, 32'h0);
        chk("route", 32'(b), 32'(rq[rt[i][0]]));
      end
      apb(8'(rt[i][2] * 4), 1'b1, 32'h0);
      apb(8'(rt[i][0] * 4), 1'b1, 32'h0);
    end
  endtask
  task automatic s_irq;
    apb(8'h14, 1'b1, 32'h19);
    apb(8'h48, 1'b1, 32'h15);
    apb(8'h44, 1'b1, 32'h15);
    apb(8'h4c, 1'b1, 32'h20);
    waitc(5);
    chk("requests", 32'h3, 32'({irqReq1, irqReq0, convStart}));
    apb(8'h44, 1'b1, 32'h1505);
    waitc(5);
    chk("requests", 32'h5, 32'({irqReq1, irqReq0, convStart}));
    apb(8'h4c, 1'b1, 32'h0);
    waitc(5);
    chk("requests", 32'h0, 32'({irqReq1, irqReq0, convStart}));
    apb(8'h14, 1'b1, 32'h0);
  endtask
  task automatic s_ff;
    logic lv;
    lv = 1'b1;
    apb(8'h00, 1'b1, 32'h18);
    apb(8'h20, 1'b1, 32'h18);
    for (int c = 0; c < 7; c++) begin
      apb(8'h40, 1'b1, 32'h70 | 32'(c));
      apb(8'h4c, 1'b1, {23'h0, lv, 7'h0, lv});
      waitc(5);
      if (c != 3) chk("held", 32'(!lv), 32'(elemOut[0]));
      pulseCode <= 3'(c);
      pulseGo <= 1'b1;
      @(posedge clk);
      pulseGo <= 1'b0;
      waitc(6);
      chk("clocked", 32'(lv), 32'(elemOut[0]));
      chk("stopped", 32'h0, 32'(elemOut[8]));
      lv = !lv;
    end
    apb(8'h40, 1'b1, 32'h37);
    apb(8'h4c, 1'b1, 32'h100);
    waitc(5);
    chk("block one", 32'h101, 32'(elemOut));
  endtask
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    waitc(4);
    rst_b <= 1'b1;
    s_regs();
    s_lut();
    s_route();
    s_irq();
    s_ff();
    report_and_stop();
  end
endmodule
